// file: hdl/gpio_map.vh
// register map, field positions and reset values of the pin port block
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// ----------------------------------------
// geometry
// ----------------------------------------
`define NUM_PINS 16
`define PINS_PER_GROUP 8

// ----------------------------------------
// address fields: addr[7:4] block, addr[3:0] register
// ----------------------------------------
`define GLOBAL_BLOCK 4'hf
`define REG_PIN_DATA 4'h0
`define REG_IO_GATE 4'h1
`define REG_PULL_CTRL 4'h2
`define REG_EDGE_FLAG 4'h3
`define REG_EDGE_CTRL 4'h4
`define REG_FILTER_EN 4'h5
`define REG_PERIPH_SEL 4'h6
`define REG_ALT_FUNC 4'h7
`define REG_FILTER_CLK 4'h0
`define REG_GROUP_SUM 4'h1

// ----------------------------------------
// fields of the filter clock control register
// ----------------------------------------
`define CLK_SRC_LSB 0
`define KEY_CFG_LSB 2
`define CLK_DIV_LSB 4
`define DBG_RUN_BIT 8
`define FILTER_CLK_MASK 9'h1ff

// ----------------------------------------
// key reset combinations on group 0
// ----------------------------------------
`define KEY_OFF 2'h0
`define KEY_PINS_1_0 2'h1
`define KEY_PINS_2_0 2'h2
`define KEY_PINS_3_0 2'h3
`define KEY_MASK_1_0 8'h03
`define KEY_MASK_2_0 8'h07
`define KEY_MASK_3_0 8'h0f

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_BITS16 16'h0000
`define RST_BITS32 32'h00000000
`define RST_FILTER_CLK 9'h000
`define RST_RDATA 16'h0000

`endif

// file: hdl/gpio_port_filter_irq_keyreset.v
// pin port block: gpio control, glitch filter, edge events and key reset
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "gpio_map.vh"

module gpio_port_filter_irq_keyreset #(
  parameter [15:0] IMPL_PINS = 16'hffff,
  parameter [15:0] GPIO_CAP = 16'hffff,
  parameter [15:0] IRQ_CAP = 16'hffff
) (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire [15:0] pin_in,
  output reg [15:0] pin_out,
  output reg [15:0] pin_oe,
  output reg [15:0] pull_up_en,
  output reg [15:0] pull_down_en,
  input wire [15:0] periph_out,
  input wire [15:0] periph_oe,
  output reg [15:0] periph_in,
  output reg [31:0] alt_function_choice,
  input wire filter_sample_tick,
  input wire deep_sleep,
  input wire sample_clock_running,
  output reg irq,
  output reg key_reset_req
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // replace byte g of a 16-bit word, keeping positions outside msk
  function [15:0] put_byte;
    input [15:0] old;
    input grp;
    input [7:0] val;
    input [15:0] msk;
    reg [15:0] nv;
    begin
      nv = grp ? {val, old[7:0]} : {old[15:8], val};
      put_byte = (nv & msk) | (old & ~msk);
    end
  endfunction

  function [7:0] get_byte;
    input [15:0] v;
    input grp;
    begin
      get_byte = grp ? v[15:8] : v[7:0];
    end
  endfunction

  // spread a 16-bit pin mask over the two-bit alternate function fields
  function [31:0] widen2;
    input [15:0] m;
    integer i;
    begin
      widen2 = 32'h00000000;
      for (i = 0; i < 16; i = i + 1) begin
        widen2[2*i] = m[i];
        widen2[2*i+1] = m[i];
      end
    end
  endfunction

  localparam [15:0] CTRL_MASK = IMPL_PINS & GPIO_CAP;
  localparam [15:0] IRQ_MASK = CTRL_MASK & IRQ_CAP;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [15:0] out_level_bits_q;
  reg [15:0] input_gate_bits_q;
  reg [15:0] drive_enable_bits_q;
  reg [15:0] pull_enable_bits_q;
  reg [15:0] pull_direction_bits_q;
  reg [15:0] edge_event_flag_q;
  reg [15:0] edge_polarity_select_q;
  reg [15:0] edge_irq_enable_q;
  reg [15:0] glitch_filter_enable_q;
  reg [15:0] peripheral_select_q;
  reg [31:0] alt_function_q;
  reg [8:0] filter_clock_control_q;
  reg [15:0] sync1_q;
  reg [15:0] sync2_q;
  reg [15:0] sample_q;
  reg [15:0] filtered_q;
  reg [15:0] prev_level_q;

  wire grp_sel = addr[4];
  wire grp_hit = (addr[7:5] == 3'h0);
  wire glb_hit = (addr[7:4] == `GLOBAL_BLOCK);
  wire [3:0] reg_idx = addr[3:0];
  wire [15:0] byte_msk = grp_sel ? 16'hff00 : 16'h00ff;
  wire wr_grp = wr & grp_hit;

  // ----------------------------------------
  // pin level path
  // ----------------------------------------
  wire [15:0] gpio_mode = ~peripheral_select_q & CTRL_MASK;
  wire filter_bypass = deep_sleep & ~sample_clock_running;
  wire [15:0] use_filter = glitch_filter_enable_q & {16{~filter_bypass}};
  wire [15:0] raw_level = (use_filter & filtered_q) | (~use_filter & sync2_q);
  wire [15:0] both_on = input_gate_bits_q & drive_enable_bits_q;
  wire [15:0] seen_level = (both_on & out_level_bits_q) | (~both_on & raw_level);
  wire [15:0] pin_level_bits = seen_level & input_gate_bits_q & gpio_mode;
  wire [15:0] rise = pin_level_bits & ~prev_level_q;
  wire [15:0] fall = ~pin_level_bits & prev_level_q;
  wire [15:0] edge_hit = ((edge_polarity_select_q & fall) | (~edge_polarity_select_q & rise)) & gpio_mode & IRQ_MASK;
  wire [15:0] pending = edge_event_flag_q & edge_irq_enable_q;
  wire [1:0] group_event_summary = {|pending[15:8], |pending[7:0]};

  // ----------------------------------------
  // input synchroniser and glitch filter
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      sync1_q <= `RST_BITS16;
      sync2_q <= `RST_BITS16;
      sample_q <= `RST_BITS16;
      filtered_q <= `RST_BITS16;
      prev_level_q <= `RST_BITS16;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_level_q <= pin_level_bits;
      if (filter_sample_tick) begin
        sample_q <= sync2_q;
        // a level is taken only after two agreeing samples
        filtered_q <= (~(sync2_q ^ sample_q) & sync2_q) | ((sync2_q ^ sample_q) & filtered_q);
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      out_level_bits_q <= `RST_BITS16;
      input_gate_bits_q <= `RST_BITS16;
      drive_enable_bits_q <= `RST_BITS16;
      pull_enable_bits_q <= `RST_BITS16;
      pull_direction_bits_q <= `RST_BITS16;
      edge_event_flag_q <= `RST_BITS16;
      edge_polarity_select_q <= `RST_BITS16;
      edge_irq_enable_q <= `RST_BITS16;
      glitch_filter_enable_q <= `RST_BITS16;
      peripheral_select_q <= `RST_BITS16;
      alt_function_q <= `RST_BITS32;
      filter_clock_control_q <= `RST_FILTER_CLK;
    end else begin
      if (wr_grp && reg_idx == `REG_PIN_DATA) begin
        out_level_bits_q <= put_byte(out_level_bits_q, grp_sel, wdata[15:8], CTRL_MASK);
      end
      if (wr_grp && reg_idx == `REG_IO_GATE) begin
        input_gate_bits_q <= put_byte(input_gate_bits_q, grp_sel, wdata[15:8], CTRL_MASK);
        drive_enable_bits_q <= put_byte(drive_enable_bits_q, grp_sel, wdata[7:0], CTRL_MASK);
      end
      if (wr_grp && reg_idx == `REG_PULL_CTRL) begin
        pull_direction_bits_q <= put_byte(pull_direction_bits_q, grp_sel, wdata[15:8], CTRL_MASK);
        pull_enable_bits_q <= put_byte(pull_enable_bits_q, grp_sel, wdata[7:0], CTRL_MASK);
      end
      if (wr_grp && reg_idx == `REG_EDGE_FLAG) begin
        // a new edge in the clearing cycle keeps the flag set
        edge_event_flag_q <= (edge_event_flag_q & ~({wdata[7:0], wdata[7:0]} & byte_msk)) | edge_hit;
      end else begin
        edge_event_flag_q <= edge_event_flag_q | edge_hit;
      end
      if (wr_grp && reg_idx == `REG_EDGE_CTRL) begin
        edge_polarity_select_q <= put_byte(edge_polarity_select_q, grp_sel, wdata[15:8], IRQ_MASK);
        edge_irq_enable_q <= put_byte(edge_irq_enable_q, grp_sel, wdata[7:0], IRQ_MASK);
      end
      if (wr_grp && reg_idx == `REG_FILTER_EN) begin
        glitch_filter_enable_q <= put_byte(glitch_filter_enable_q, grp_sel, wdata[7:0], IMPL_PINS);
      end
      if (wr_grp && reg_idx == `REG_PERIPH_SEL) begin
        peripheral_select_q <= put_byte(peripheral_select_q, grp_sel, wdata[7:0], IMPL_PINS);
      end
      if (wr_grp && reg_idx == `REG_ALT_FUNC) begin
        if (grp_sel) begin
          alt_function_q <= ({wdata, alt_function_q[15:0]} & widen2(IMPL_PINS)) | (alt_function_q & ~widen2(IMPL_PINS) & 32'hffff0000);
        end else begin
          alt_function_q <= ({alt_function_q[31:16], wdata} & widen2(IMPL_PINS)) | (alt_function_q & ~widen2(IMPL_PINS) & 32'h0000ffff);
        end
      end
      if (wr && glb_hit && reg_idx == `REG_FILTER_CLK) begin
        filter_clock_control_q <= wdata[8:0] & `FILTER_CLK_MASK;
      end
    end
  end

  // ----------------------------------------
  // register reads, data one cycle after the strobe
  // ----------------------------------------
  reg [15:0] rd_mux;
  always @* begin
    rd_mux = 16'h0000;
    if (grp_hit) begin
      case (reg_idx)
        `REG_PIN_DATA: rd_mux = {get_byte(out_level_bits_q, grp_sel), get_byte(pin_level_bits, grp_sel)};
        `REG_IO_GATE: rd_mux = {get_byte(input_gate_bits_q, grp_sel), get_byte(drive_enable_bits_q, grp_sel)};
        `REG_PULL_CTRL: rd_mux = {get_byte(pull_direction_bits_q, grp_sel), get_byte(pull_enable_bits_q, grp_sel)};
        `REG_EDGE_FLAG: rd_mux = {8'h00, get_byte(edge_event_flag_q, grp_sel)};
        `REG_EDGE_CTRL: rd_mux = {get_byte(edge_polarity_select_q, grp_sel), get_byte(edge_irq_enable_q, grp_sel)};
        `REG_FILTER_EN: rd_mux = {8'h00, get_byte(glitch_filter_enable_q, grp_sel)};
        `REG_PERIPH_SEL: rd_mux = {8'h00, get_byte(peripheral_select_q, grp_sel)};
        `REG_ALT_FUNC: rd_mux = grp_sel ? alt_function_q[31:16] : alt_function_q[15:0];
        default: rd_mux = 16'h0000;
      endcase
    end else if (glb_hit) begin
      case (reg_idx)
        `REG_FILTER_CLK: rd_mux = {7'h00, filter_clock_control_q};
        `REG_GROUP_SUM: rd_mux = {14'h0000, group_event_summary};
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rdata <= `RST_RDATA;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= `RST_RDATA;
    end
  end

  // ----------------------------------------
  // pad drive, pulls, peripheral routing
  // ----------------------------------------
  reg [7:0] key_mask;
  always @* begin
    case (filter_clock_control_q[`KEY_CFG_LSB+1:`KEY_CFG_LSB])
      `KEY_PINS_3_0: key_mask = `KEY_MASK_3_0;
      `KEY_PINS_2_0: key_mask = `KEY_MASK_2_0;
      `KEY_PINS_1_0: key_mask = `KEY_MASK_1_0;
      default: key_mask = 8'h00;
    endcase
  end

  wire [15:0] gpio_drive = gpio_mode & drive_enable_bits_q;
  wire [15:0] gpio_pull = gpio_mode & ~drive_enable_bits_q & pull_enable_bits_q;

  always @(posedge clk) begin
    if (rst) begin
      pin_out <= `RST_BITS16;
      pin_oe <= `RST_BITS16;
      pull_up_en <= `RST_BITS16;
      pull_down_en <= `RST_BITS16;
      periph_in <= `RST_BITS16;
      alt_function_choice <= `RST_BITS32;
      irq <= 1'b0;
      key_reset_req <= 1'b0;
    end else begin
      pin_oe <= (peripheral_select_q & IMPL_PINS & periph_oe) | gpio_drive;
      pin_out <= (peripheral_select_q & IMPL_PINS & periph_oe & periph_out) | (gpio_drive & out_level_bits_q);
      pull_up_en <= gpio_pull & pull_direction_bits_q;
      pull_down_en <= gpio_pull & ~pull_direction_bits_q;
      periph_in <= peripheral_select_q & IMPL_PINS & sync2_q;
      alt_function_choice <= alt_function_q;
      irq <= |pending;
      key_reset_req <= (|key_mask) & ((pin_level_bits[7:0] & key_mask) == 8'h00);
    end
  end

endmodule // gpio_port_filter_irq_keyreset

// file: tb/gpio_port_props.sv
// concurrent checks on the pin port block ports
`timescale 1ns/100ps
module gpio_port_props (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire [15:0] pin_out,
  input wire [15:0] pin_oe,
  input wire [15:0] pull_up_en,
  input wire [15:0] pull_down_en,
  input wire [15:0] periph_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // named bus steps
  // ----------------------------------------
  sequence s_rd_unmapped;
    rd && addr[7:5] != 3'h0 && addr[7:4] != 4'hf;
  endsequence
  sequence s_rd_narrow;
    rd && addr[7:5] == 3'h0 && (addr[3:0] == 4'h3 || addr[3:0] == 4'h5 || addr[3:0] == 4'h6);
  endsequence
  sequence s_rd_summary;
    rd && addr == 8'hf1;
  endsequence
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside the read slot");
  a_unmapped_zero: assert property (s_rd_unmapped |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (s_rd_narrow |=> rdata[15:8] == 8'h00)
    else $error("absent bits read nonzero");
  a_summary_width: assert property (s_rd_summary |=> rdata[15:2] == 14'h0000)
    else $error("summary holds bits beyond two groups");
  a_pull_excl: assert property ((pull_up_en & pull_down_en) == 16'h0000)
    else $error("pull up and down together");
  a_pull_drive: assert property ((pin_oe & (pull_up_en | pull_down_en)) == 16'h0000)
    else $error("pull active on driven pin");
  a_out_quiet: assert property ((pin_out & ~pin_oe) == 16'h0000)
    else $error("output level on undriven pin");
  a_reset_quiet: assert property ($fell(rst) |-> (pin_oe | pull_up_en | pull_down_en) == 16'h0000)
    else $error("pin not idle after reset");
  a_oe_cause: assert property ($changed(pin_oe) |-> $past(wr) || $past(wr, 2)
    || $past(periph_oe) != $past(periph_oe, 2))
    else $error("drive enable changed without cause");
endmodule // gpio_port_props

bind gpio_port_filter_irq_keyreset gpio_port_props u_props (.clk(clk), .rst(rst), .addr(addr), .wr(wr),
  .rd(rd), .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en), .periph_oe(periph_oe));

// file: tb/pad_model.sv
// pad model: resolves each pin from device drive, outside drive and pulls
`timescale 1ns/100ps
module pad_model (
  input wire clk,
  input wire [15:0] pin_out,
  input wire [15:0] pin_oe,
  input wire [15:0] pull_up_en,
  input wire [15:0] pull_down_en,
  input wire [15:0] ext_val,
  input wire [15:0] ext_en,
  output wire [15:0] pin_in
);
  reg [15:0] float_q = 16'h0000;
  // undriven pads with no pull enabled wander every cycle
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  assign pin_in = (pin_oe & pin_out)
    | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pull_up_en | (~pull_down_en & float_q)));
endmodule // pad_model

// file: tb/tb_top.sv
// self-checking bench for the pin port block
`timescale 1ns/100ps
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [15:0] periph_out = 16'h0000;
  reg [15:0] periph_oe = 16'h0000;
  reg filter_sample_tick = 1'b0;
  reg deep_sleep = 1'b0;
  reg sample_clock_running = 1'b1;
  reg [15:0] ext_val = 16'h0000;
  reg [15:0] ext_en = 16'h00ff;
  wire [15:0] rdata, pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, periph_in;
  wire irq, key_reset_req;
  integer err_count = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer k;
  reg [15:0] m;
  always #5 clk = ~clk;
  gpio_port_filter_irq_keyreset dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
    .alt_function_choice(), .filter_sample_tick(filter_sample_tick), .deep_sleep(deep_sleep),
    .sample_clock_running(sample_clock_running), .irq(irq), .key_reset_req(key_reset_req));
  pad_model pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  // ----------------------------------------
  // sample tick every fourth cycle, hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    filter_sample_tick <= (cyc % 4 == 3);
    if (cyc == 5000) begin
      err_count = err_count + 1;
      wrap_up;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string name, input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
        err_count = err_count + 1;
      end
    end
  endtask
  task wreg(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rchk(input [7:0] a, input [15:0] exp);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", rdata, exp);
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task setpad(input [15:0] v);
    begin
      @(posedge clk);
      ext_val <= v;
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h01, 16'h0000);
    rchk(8'h02, 16'h0000);
    chk("pin_oe", pin_oe, 16'h0000);
    $display("test reset done");
    wreg(8'h00, 16'ha500);
    idle(3);
    chk("pin_oe", pin_oe, 16'h0000);
    wreg(8'h01, 16'hffff);
    idle(5);
    chk("pin_out", pin_out, 16'h00a5);
    chk("pin_oe", pin_oe, 16'h00ff);
    rchk(8'h00, 16'ha5a5);
    setpad(16'h003c);
    wreg(8'h01, 16'hff00);
    idle(5);
    rchk(8'h00, 16'ha53c);
    wreg(8'h01, 16'h0000);
    idle(5);
    rchk(8'h00, 16'ha500);
    wreg(8'h02, 16'h0f33);
    idle(3);
    chk("pull_up_en", pull_up_en, 16'h0003);
    chk("pull_down_en", pull_down_en, 16'h0030);
    $display("test gpio done");
    wreg(8'h04, 16'h0000);
    setpad(16'h0000);
    wreg(8'h03, 16'h00ff);
    wreg(8'h04, 16'h0f01);
    wreg(8'h01, 16'hff00);
    setpad(16'h00ff);
    idle(6);
    rchk(8'h03, 16'h00f0);
    chk("irq", {15'h0000, irq}, 16'h0000);
    rchk(8'hf1, 16'h0000);
    setpad(16'h0000);
    idle(6);
    rchk(8'h03, 16'h00ff);
    chk("irq", {15'h0000, irq}, 16'h0001);
    rchk(8'hf1, 16'h0001);
    wreg(8'h03, 16'h000e);
    rchk(8'h03, 16'h00f1);
    wreg(8'h03, 16'h0001);
    idle(3);
    chk("irq", {15'h0000, irq}, 16'h0000);
    rchk(8'hf1, 16'h0000);
    $display("test events done");
    for (k = 1; k < 4; k = k + 1) begin
      m = (16'h0001 << (k + 1)) - 16'h0001;
      setpad(16'h00ff);
      wreg(8'hf0, {12'h000, k[1:0], 2'h0});
      idle(5);
      chk("key_reset_req", {15'h0000, key_reset_req}, 16'h0000);
      setpad((~m & 16'h00ff) | (m ^ (m >> 1)));
      idle(5);
      chk("key_reset_req", {15'h0000, key_reset_req}, 16'h0000);
      setpad(~m & 16'h00ff);
      idle(5);
      chk("key_reset_req", {15'h0000, key_reset_req}, 16'h0001);
      rchk(8'h00, {8'ha5, ~m[7:0]});
    end
    wreg(8'hf0, 16'h0000);
    idle(5);
    chk("key_reset_req", {15'h0000, key_reset_req}, 16'h0000);
    $display("test key reset done");
    setpad(16'h00ff);
    periph_oe <= 16'h0080;
    periph_out <= 16'h0080;
    wreg(8'h06, 16'h0080);
    idle(5);
    chk("pin_oe", pin_oe, 16'h0080);
    chk("periph_in", periph_in, 16'h0080);
    rchk(8'h00, 16'ha57f);
    wreg(8'h04, 16'h0000);
    wreg(8'h05, 16'hffff);
    rchk(8'h05, 16'h00ff);
    wreg(8'h20, 16'hffff);
    rchk(8'h20, 16'h0000);
    idle(20);
    setpad(16'h00fd);
    setpad(16'h00ff);
    idle(20);
    rchk(8'h00, 16'ha57f);
    setpad(16'h00fd);
    idle(20);
    rchk(8'h00, 16'ha57d);
    setpad(16'h00fb);
    deep_sleep <= 1'b1;
    sample_clock_running <= 1'b0;
    idle(1);
    rchk(8'h00, 16'ha57b);
    @(posedge clk);
    deep_sleep <= 1'b0;
    sample_clock_running <= 1'b1;
    $display("test filter done");
    wrap_up;
  end
endmodule // tb_top
